// ==== rtl/airss_regs.vh ====
// register map, field positions and reset values of the interrupt status block
// assumes byte-wide registers at 16-bit addresses on the control port
`ifndef AIRSS_REGS_VH
`define AIRSS_REGS_VH

`define AIRSS_ADDR_W              16
`define AIRSS_DATA_W              8

`define AIRSS_RAW_THERMAL_ADDR    16'h2001
`define AIRSS_RAW_CLOCK_ADDR      16'h2002
`define AIRSS_RAW_POWER_ADDR      16'h2003
`define AIRSS_STICKY_THERMAL_ADDR 16'h2006
`define AIRSS_STICKY_CLOCK_ADDR   16'h2007
`define AIRSS_FLAG_THERMAL_ADDR   16'h200B
`define AIRSS_FLAG_CLOCK_ADDR     16'h200C
`define AIRSS_CLEAR_THERMAL_ADDR  16'h2010
`define AIRSS_CLEAR_CLOCK_ADDR    16'h2011
`define AIRSS_ENABLE_THERMAL_ADDR 16'h2012
`define AIRSS_ENABLE_CLOCK_ADDR   16'h2013
`define AIRSS_IRQ_CTRL_ADDR       16'h2014

`define AIRSS_RESET_VALUE         8'h00
`define AIRSS_CLOCK_USED_MASK     8'h37
`define AIRSS_IRQ_EN_BIT          0

`define AIRSS_BIT_OVERTEMP_BGN    7
`define AIRSS_BIT_OVERTEMP_END    6
`define AIRSS_BIT_WARN_BGN        5
`define AIRSS_BIT_WARN_END        4
`define AIRSS_BIT_FOLDBACK_BGN    3
`define AIRSS_BIT_FOLDBACK_END    2
`define AIRSS_BIT_TRIM_FAIL       1
`define AIRSS_BIT_OVERCURRENT     0

`define AIRSS_BIT_INT_SPKMON      5
`define AIRSS_BIT_INT_CLOCK       4
`define AIRSS_BIT_CLK_RECOVERY    2
`define AIRSS_BIT_EXT_CLOCK       1
`define AIRSS_BIT_EXT_DATAMON     0

`define AIRSS_BIT_POWERUP         5
`define AIRSS_BIT_POWERDOWN       4
`define AIRSS_BIT_POWER_UV        3
`define AIRSS_BIT_BATTERY_UV      2
`define AIRSS_BIT_TRACK_BGN       1
`define AIRSS_BIT_TRACK_END       0

`endif

// ==== rtl/airss_top.v ====
// interrupt raw, sticky state and flag logic of the speaker amplifier
// assumes raw indicator levels synchronous to mclk and a byte-wide
// register port driven by the control bus front end in the same domain
`timescale 1ns/100ps
`include "airss_regs.vh"

// Summary of operation
// RQ1 - raw clock bit0 follows external data monitor
// RQ2 - raw power bit5 shows power-up complete
// RQ3 - raw power bit4 shows power-down complete
// RQ4 - raw power bit3 shows power rail undervoltage
// RQ5 - raw power bit2 shows battery rail undervoltage
// RQ6 - raw power bit1 shows headroom tracking active
// RQ7 - raw power bit0 shows headroom tracking ended
// RQ8 - sticky bit7 latches overtemp shutdown begin edge
// RQ9 - sticky bit6 latches overtemp shutdown end edge
// RQ10 - sticky bit5 latches temp warning begin edge
// RQ11 - sticky bit4 latches temp warning end edge
// RQ12 - sticky bit3 latches foldback begin edge
// RQ13 - sticky bit2 latches foldback end edge
// RQ14 - sticky bit1 latches trim load failure edge
// RQ15 - sticky bit0 latches overcurrent edge, its flag gated by enable bit0
// RQ16 - clock sticky bit5 latches internal monitor fault
// RQ17 - clock sticky bit4 latches internal clock fault
// RQ18 - clock sticky bit2 latches clock recovery edge
// RQ19 - clock sticky bit1 latches external clock fault
// RQ20 - flags are sticky gated by enable; edge interrupts
// RQ21 - write one clears; coincident edge keeps bit set
module airss_top #(
   parameter DATA_W = `AIRSS_DATA_W,
   parameter ADDR_W = `AIRSS_ADDR_W
) (
   input  wire              mclk,
   input  wire              rst,
   input  wire              overtemp_shutdown_begin_level,
   input  wire              overtemp_shutdown_end_level,
   input  wire              temp_warning_begin_level,
   input  wire              temp_warning_end_level,
   input  wire              temp_foldback_begin_level,
   input  wire              temp_foldback_end_level,
   input  wire              trim_load_failure_level,
   input  wire              speaker_overcurrent_level,
   input  wire              internal_speaker_monitor_fault_level,
   input  wire              internal_clock_fault_level,
   input  wire              clock_fault_recovery_level,
   input  wire              external_clock_fault_level,
   input  wire              ext_data_monitor_fault_level,
   input  wire              powerup_complete_level,
   input  wire              powerdown_complete_level,
   input  wire              power_rail_undervolt_level,
   input  wire              battery_rail_undervolt_level,
   input  wire              headroom_track_begin_level,
   input  wire              headroom_track_end_level,
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire              reg_wr_en,
   input  wire [DATA_W-1:0] reg_wdata,
   input  wire              reg_rd_en,
   output reg  [DATA_W-1:0] reg_rdata,
   output reg               reg_rd_valid,
   output reg               irq_pulse
);

   // live raw levels, captured once so edge detect and readback agree
   reg  [7:0] raw_thermal_r;
   reg  [7:0] raw_clock_r;
   reg  [7:0] raw_power_r;
   reg  [7:0] prev_thermal_r;
   reg  [7:0] prev_clock_r;
   reg  [7:0] sticky_thermal_r;
   reg  [7:0] sticky_clock_r;
   reg  [7:0] enable_thermal_r;
   reg  [7:0] enable_clock_r;
   reg  [7:0] flag_thermal_r;
   reg  [7:0] flag_clock_r;
   reg        irq_en_r;

   reg  [7:0] raw_thermal_nxt;
   reg  [7:0] raw_clock_nxt;
   reg  [7:0] raw_power_nxt;
   reg  [7:0] rise_thermal;
   reg  [7:0] rise_clock;
   reg  [7:0] clear_thermal;
   reg  [7:0] clear_clock;
   reg  [7:0] sticky_thermal_nxt;
   reg  [7:0] sticky_clock_nxt;
   reg  [7:0] flag_thermal_nxt;
   reg  [7:0] flag_clock_nxt;
   reg        irq_nxt;
   reg  [7:0] rdata_nxt;

   always @*
   begin
      raw_thermal_nxt = `AIRSS_RESET_VALUE;
      raw_thermal_nxt[`AIRSS_BIT_OVERTEMP_BGN] = overtemp_shutdown_begin_level;
      raw_thermal_nxt[`AIRSS_BIT_OVERTEMP_END] = overtemp_shutdown_end_level;
      raw_thermal_nxt[`AIRSS_BIT_WARN_BGN]     = temp_warning_begin_level;
      raw_thermal_nxt[`AIRSS_BIT_WARN_END]     = temp_warning_end_level;
      raw_thermal_nxt[`AIRSS_BIT_FOLDBACK_BGN] = temp_foldback_begin_level;
      raw_thermal_nxt[`AIRSS_BIT_FOLDBACK_END] = temp_foldback_end_level;
      raw_thermal_nxt[`AIRSS_BIT_TRIM_FAIL]    = trim_load_failure_level;
      raw_thermal_nxt[`AIRSS_BIT_OVERCURRENT]  = speaker_overcurrent_level;

      raw_clock_nxt = `AIRSS_RESET_VALUE;
      raw_clock_nxt[`AIRSS_BIT_INT_SPKMON]     = internal_speaker_monitor_fault_level;
      raw_clock_nxt[`AIRSS_BIT_INT_CLOCK]      = internal_clock_fault_level;
      raw_clock_nxt[`AIRSS_BIT_CLK_RECOVERY]   = clock_fault_recovery_level;
      raw_clock_nxt[`AIRSS_BIT_EXT_CLOCK]      = external_clock_fault_level;
      raw_clock_nxt[`AIRSS_BIT_EXT_DATAMON]    = ext_data_monitor_fault_level; // RQ1

      raw_power_nxt = `AIRSS_RESET_VALUE;
      raw_power_nxt[`AIRSS_BIT_POWERUP]        = powerup_complete_level;       // RQ2
      raw_power_nxt[`AIRSS_BIT_POWERDOWN]      = powerdown_complete_level;     // RQ3
      raw_power_nxt[`AIRSS_BIT_POWER_UV]       = power_rail_undervolt_level;   // RQ4
      raw_power_nxt[`AIRSS_BIT_BATTERY_UV]     = battery_rail_undervolt_level; // RQ5
      raw_power_nxt[`AIRSS_BIT_TRACK_BGN]      = headroom_track_begin_level;   // RQ6
      raw_power_nxt[`AIRSS_BIT_TRACK_END]      = headroom_track_end_level;     // RQ7
   end

   // rising edges of the captured raw levels
   always @*
   begin
      rise_thermal = raw_thermal_r & ~prev_thermal_r; // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14
      rise_clock   = raw_clock_r & ~prev_clock_r & `AIRSS_CLOCK_USED_MASK; // RQ16 RQ17 RQ18 RQ19
   end

   // clear strobes are write-one pulses, they store nothing
   always @*
   begin
      clear_thermal = `AIRSS_RESET_VALUE;
      clear_clock   = `AIRSS_RESET_VALUE;
      if (reg_wr_en && reg_addr == `AIRSS_CLEAR_THERMAL_ADDR)
      begin
         clear_thermal = reg_wdata[7:0]; // RQ21
      end
      if (reg_wr_en && reg_addr == `AIRSS_CLEAR_CLOCK_ADDR)
      begin
         clear_clock = reg_wdata[7:0]; // RQ21
      end
   end

   // a new edge in the clear cycle wins so no event is lost
   always @*
   begin
      sticky_thermal_nxt = (sticky_thermal_r & ~clear_thermal) | rise_thermal; // RQ15 RQ21
      sticky_clock_nxt   = (sticky_clock_r & ~clear_clock) | rise_clock;       // RQ21
      flag_thermal_nxt   = sticky_thermal_nxt & enable_thermal_r; // RQ20
      flag_clock_nxt     = sticky_clock_nxt & enable_clock_r;     // RQ20
      irq_nxt = irq_en_r &
                (|(flag_thermal_nxt & ~flag_thermal_r) |
                 |(flag_clock_nxt & ~flag_clock_r)); // RQ20
   end

   // readback; unmapped addresses and clear registers read zero
   always @*
   begin
      case (reg_addr)
         `AIRSS_RAW_THERMAL_ADDR:    rdata_nxt = raw_thermal_r;
         `AIRSS_RAW_CLOCK_ADDR:      rdata_nxt = raw_clock_r;      // RQ1
         `AIRSS_RAW_POWER_ADDR:      rdata_nxt = raw_power_r;      // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7
         `AIRSS_STICKY_THERMAL_ADDR: rdata_nxt = sticky_thermal_r; // RQ8
         `AIRSS_STICKY_CLOCK_ADDR:   rdata_nxt = sticky_clock_r;   // RQ16
         `AIRSS_FLAG_THERMAL_ADDR:   rdata_nxt = flag_thermal_r;
         `AIRSS_FLAG_CLOCK_ADDR:     rdata_nxt = flag_clock_r;
         `AIRSS_ENABLE_THERMAL_ADDR: rdata_nxt = enable_thermal_r;
         `AIRSS_ENABLE_CLOCK_ADDR:   rdata_nxt = enable_clock_r;
         `AIRSS_IRQ_CTRL_ADDR:       rdata_nxt = {7'h00, irq_en_r};
         default:                    rdata_nxt = `AIRSS_RESET_VALUE;
      endcase
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         raw_thermal_r    <= `AIRSS_RESET_VALUE;
         raw_clock_r      <= `AIRSS_RESET_VALUE;
         raw_power_r      <= `AIRSS_RESET_VALUE;
         prev_thermal_r   <= `AIRSS_RESET_VALUE;
         prev_clock_r     <= `AIRSS_RESET_VALUE;
         sticky_thermal_r <= `AIRSS_RESET_VALUE;
         sticky_clock_r   <= `AIRSS_RESET_VALUE;
         enable_thermal_r <= `AIRSS_RESET_VALUE;
         enable_clock_r   <= `AIRSS_RESET_VALUE;
         flag_thermal_r   <= `AIRSS_RESET_VALUE;
         flag_clock_r     <= `AIRSS_RESET_VALUE;
         irq_en_r         <= 1'b0;
         irq_pulse        <= 1'b0;
         reg_rdata        <= `AIRSS_RESET_VALUE;
         reg_rd_valid     <= 1'b0;
      end
      else
      begin
         // a level already high when reset drops counts as an edge
         raw_thermal_r    <= raw_thermal_nxt;
         raw_clock_r      <= raw_clock_nxt;
         raw_power_r      <= raw_power_nxt;
         prev_thermal_r   <= raw_thermal_r;
         prev_clock_r     <= raw_clock_r;
         sticky_thermal_r <= sticky_thermal_nxt;
         sticky_clock_r   <= sticky_clock_nxt;
         flag_thermal_r   <= flag_thermal_nxt;
         flag_clock_r     <= flag_clock_nxt;
         irq_pulse        <= irq_nxt;
         if (reg_wr_en && reg_addr == `AIRSS_ENABLE_THERMAL_ADDR)
         begin
            enable_thermal_r <= reg_wdata[7:0];
         end
         if (reg_wr_en && reg_addr == `AIRSS_ENABLE_CLOCK_ADDR)
         begin
            enable_clock_r <= reg_wdata[7:0] & `AIRSS_CLOCK_USED_MASK;
         end
         if (reg_wr_en && reg_addr == `AIRSS_IRQ_CTRL_ADDR)
         begin
            irq_en_r <= reg_wdata[`AIRSS_IRQ_EN_BIT];
         end
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en)
         begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

endmodule // airss_top

// ==== tb/airss_chk.sv ====
// checker of the status block read port and thermal sticky bits
// assumes it is bound onto airss_top, one mclk domain, synchronous rst
`timescale 1ns/100ps
module airss_chk (
   input wire        mclk,
   input wire        rst,
   input wire        overtemp_shutdown_begin_level,
   input wire        overtemp_shutdown_end_level,
   input wire        temp_warning_begin_level,
   input wire        temp_warning_end_level,
   input wire        temp_foldback_begin_level,
   input wire        temp_foldback_end_level,
   input wire        trim_load_failure_level,
   input wire        speaker_overcurrent_level,
   input wire        ext_data_monitor_fault_level,
   input wire [15:0] reg_addr,
   input wire        reg_wr_en,
   input wire [7:0]  reg_wdata,
   input wire        reg_rd_en,
   input wire [7:0]  reg_rdata,
   input wire        reg_rd_valid
);
   wire [7:0] th = {overtemp_shutdown_begin_level, overtemp_shutdown_end_level,
      temp_warning_begin_level, temp_warning_end_level, temp_foldback_begin_level,
      temp_foldback_end_level, trim_load_failure_level, speaker_overcurrent_level};
   reg  [2:0] age_r;
   // edge checks look four cycles back, so wait until that history is past reset
   always @(posedge mclk)
      age_r <= rst ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid)
      else $error("read without valid");
   AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid)
      else $error("valid without read");
   AST_RDATA_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved between reads");
   AST_RAW_DMON: assert property (age_r == 3'h7 && reg_rd_en && reg_addr == 16'h2002
      |=> reg_rdata[0] == $past(ext_data_monitor_fault_level, 2))
      else $error("data monitor raw bit wrong");
   AST_RAW_RSV: assert property (reg_rd_en && reg_addr == 16'h2002
      |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3])
      else $error("unused raw clock bits set");
   AST_STICKY_TH: assert property (age_r == 3'h7 && reg_rd_en && reg_addr == 16'h2006
      |=> (reg_rdata & $past(th, 3) & ~$past(th, 4)) == ($past(th, 3) & ~$past(th, 4)))
      else $error("thermal sticky bit missed an edge");
   AST_CLEAR_TH: assert property (age_r == 3'h7 && reg_wr_en && reg_addr == 16'h2010
      ##1 reg_rd_en && reg_addr == 16'h2006
      |=> (reg_rdata & $past(reg_wdata, 2) & ~($past(th, 3) & ~$past(th, 4))) == 8'h00)
      else $error("thermal sticky bit survived its clear");
   AST_CLR_READ0: assert property (reg_rd_en && reg_addr[15:1] == 15'h1008
      |=> reg_rdata == 8'h00)
      else $error("clear register read not zero");
endmodule // airss_chk
bind airss_top airss_chk i_chk (.*);

// ==== tb/airss_host.sv ====
// host model driving the byte register port of the status block
// assumes one request per mclk cycle, changed 1 ns after the rising edge
`timescale 1ns/100ps
module airss_host (
   input  wire        mclk,
   input  wire [7:0]  reg_rdata,
   output reg  [15:0] reg_addr,
   output reg         reg_wr_en,
   output reg         reg_rd_en,
   output reg  [7:0]  reg_wdata
);
   initial
      {reg_addr, reg_wr_en, reg_rd_en, reg_wdata} = 26'h0;
   // held through the sampling edge; idle write data toggles so it never looks valid
   task op(input w, input r, input [15:0] a, input [7:0] d, output [7:0] q);
   begin
      reg_wr_en = w;
      reg_rd_en = r;
      reg_addr = a;
      reg_wdata = w ? d : ~reg_wdata;
      @(posedge mclk);
      #1 q = reg_rdata;
   end
   endtask
endmodule // airss_host

// ==== tb/tb_top.sv ====
// self-checking bench of the interrupt status block, random levels plus corners
// assumes airss_host drives the register port and airss_chk is bound to the top
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
   reg         mclk = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  th = 8'h00;
   reg  [4:0]  ck = 5'h00;
   reg  [5:0]  pw = 6'h00;
   reg  [7:0]  q, en1, en2, st1, st2, o1, o2;
   reg  [31:0] r;
   wire [15:0] reg_addr;
   wire [7:0]  reg_wdata, reg_rdata;
   wire        reg_wr_en, reg_rd_en, reg_rd_valid, irq_pulse;
   integer     seed = 32'h337f;
   integer     fails = 0;
   integer     cmp_count = 0;
   integer     irq_n = 0;
   integer     irq_exp = 0;
   integer     i;
   always #10 mclk = ~mclk;
   always @(posedge mclk)
      if (irq_pulse === 1'b1)
         irq_n = irq_n + 1;
   airss_top i_dut (.mclk(mclk), .rst(rst),
      .overtemp_shutdown_begin_level(th[7]), .overtemp_shutdown_end_level(th[6]),
      .temp_warning_begin_level(th[5]), .temp_warning_end_level(th[4]),
      .temp_foldback_begin_level(th[3]), .temp_foldback_end_level(th[2]),
      .trim_load_failure_level(th[1]), .speaker_overcurrent_level(th[0]),
      .internal_speaker_monitor_fault_level(ck[4]), .internal_clock_fault_level(ck[3]),
      .clock_fault_recovery_level(ck[2]), .external_clock_fault_level(ck[1]),
      .ext_data_monitor_fault_level(ck[0]), .powerup_complete_level(pw[5]),
      .powerdown_complete_level(pw[4]), .power_rail_undervolt_level(pw[3]),
      .battery_rail_undervolt_level(pw[2]), .headroom_track_begin_level(pw[1]),
      .headroom_track_end_level(pw[0]), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .irq_pulse(irq_pulse));
   airss_host i_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));
   function [7:0] cmap(input [4:0] c);
      cmap = {2'h0, c[4:3], 1'b0, c[2:0]};
   endfunction
   function [7:0] rise(input [7:0] o, input [7:0] n);
      rise = n & ~o;
   endfunction
   task idle;
      i_host.op(1'b0, 1'b0, 16'h0000, 8'h00, q);
   endtask
   task wr(input [15:0] a, input [7:0] d);
      i_host.op(1'b1, 1'b0, a, d, q);
   endtask
   task rd(input [15:0] a, input [7:0] e);
   begin
      i_host.op(1'b0, 1'b1, a, 8'h00, q);
      `CHK(reg_rd_valid, 1'b1)
      `CHK(q, e)
   end
   endtask
   task wrap_up;
   begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      for (i = 16'h2001; i <= 16'h2014; i = i + 1)
         rd(i[15:0], 8'h00); // reset values, and unmapped places read zero
      $display("test reset done");
      r = $random(seed);
      en1 = r[7:0];
      en2 = r[15:8] & 8'h37;
      wr(16'h2014, 8'h01);
      wr(16'h2012, en1);
      wr(16'h2013, r[15:8]);
      rd(16'h2013, en2);
      st1 = 8'h00;
      st2 = 8'h00;
      for (i = 0; i < 40; i = i + 1)
      begin
         o1 = th;
         o2 = cmap(ck);
         r = $random(seed);
         th = r[7:0];
         ck = r[12:8];
         pw = r[18:13];
         if (|(rise(o1, th) & en1 & ~st1 | rise(o2, cmap(ck)) & en2 & ~st2))
            irq_exp = irq_exp + 1;
         st1 = st1 | rise(o1, th);
         st2 = st2 | rise(o2, cmap(ck));
         idle;
         rd(16'h2002, cmap(ck));
         rd(16'h2003, {2'h0, pw});
         rd(16'h2006, st1);
         rd(16'h2007, st2);
         rd(16'h200B, st1 & en1);
         rd(16'h200C, st2 & en2);
         r = $random(seed);
         wr(16'h2010, r[7:0]);
         wr(16'h2011, r[15:8]);
         st1 = st1 & ~r[7:0];
         st2 = st2 & ~r[15:8];
      end
      $display("test random done");
      th = 8'h00;
      idle;
      wr(16'h2010, 8'hFF);
      th = 8'h01;
      idle;
      wr(16'h2010, 8'hFF);
      rd(16'h2006, 8'h01);
      irq_exp = irq_exp + en1[0];
      wr(16'h2006, 8'hFE);
      wr(16'h2010, 8'hFE);
      rd(16'h2006, 8'h01);
      wr(16'h2010, 8'h01);
      rd(16'h2006, 8'h00);
      idle;
      `CHK(irq_n, irq_exp)
      $display("test corner done");
      wrap_up;
   end
   initial
   begin
      #50000;
      fails = fails + 1;
      wrap_up;
   end
endmodule // tb_top
